// [rtl/uart_regs_pkg.sv]
// constants, register ids and the register layout of one uart channel
package uart_regs_pkg;

  localparam int          DATA_W         = 8;
  localparam int          ADDR_W         = 3;

  localparam logic [2:0]  OFS_HOLD       = 3'h0;
  localparam logic [2:0]  OFS_IER        = 3'h1;
  localparam logic [2:0]  OFS_ISR        = 3'h2;
  localparam logic [2:0]  OFS_LCR        = 3'h3;
  localparam logic [2:0]  OFS_MCR        = 3'h4;
  localparam logic [2:0]  OFS_LSR        = 3'h5;
  localparam logic [2:0]  OFS_MSR        = 3'h6;
  localparam logic [2:0]  OFS_SPR        = 3'h7;

  localparam int          LCR_DIV_BIT    = 7;
  localparam int          FEATURE_CONTROL_SWAP_BIT  = 6;
  localparam int          FEATURE_CONTROL_TXSEL_BIT = 7;
  localparam int          ENHANCED_MODE_SELECT_TXSEL_BIT = 0;
  localparam int          AFR_CONC_BIT   = 0;

  localparam logic [7:0]  ENH_KEY        = 8'hBF;
  localparam logic [7:0]  RST_ZERO       = 8'h00;
  localparam logic [7:0]  RST_SPR        = 8'hFF;
  localparam logic [7:0]  RST_ENHANCED_MODE_SELECT       = 8'h80;

  typedef enum logic [4:0] {
    REG_NONE, REG_HOLD, REG_DLL, REG_DLM, REG_AFR, REG_REV, REG_IDENT,
    REG_IER, REG_ISR, REG_FCR, REG_LCR, REG_MCR, REG_LSR, REG_MSR,
    REG_SPR, REG_FIFO_LEVEL_STATUS, REG_ENHANCED_MODE_SELECT, REG_TRG, REG_FC, REG_FEATURE_CONTROL, REG_EFR,
    REG_XON1, REG_XON2, REG_XOFF1, REG_XOFF2
  } reg_id_t;

  typedef struct packed {
    logic [7:0] line_control;
    logic [7:0] interrupt_enable;
    logic [7:0] fifo_control;
    logic [7:0] modem_control;
    logic [7:0] dll;
    logic [7:0] divisor_high;
    logic [7:0] alternate_function;
    logic [7:0] feature_control;
    logic [7:0] enhanced_function;
    logic [7:0] fifo_trigger_level;
    logic [7:0] enhanced_mode_select;
    logic [7:0] scratch_pad;
    logic [7:0] xon1;
    logic [7:0] xon2;
    logic [7:0] xoff1;
    logic [7:0] xoff2;
  } chan_regs_t;

  localparam chan_regs_t CH_RESET = '{
    line_control: RST_ZERO, interrupt_enable: RST_ZERO, fifo_control: RST_ZERO, modem_control: RST_ZERO,
    dll: RST_ZERO, divisor_high: RST_ZERO, alternate_function: RST_ZERO, feature_control: RST_ZERO,
    enhanced_function: RST_ZERO, fifo_trigger_level: RST_ZERO, enhanced_mode_select: RST_ENHANCED_MODE_SELECT, scratch_pad: RST_SPR,
    xon1: RST_ZERO, xon2: RST_ZERO, xoff1: RST_ZERO, xoff2: RST_ZERO};

endpackage

// [rtl/reg_sel_if.sv]
// register selection signals between decoder, read mux and channel bank
`timescale 1ns/10ps
interface reg_sel_if;
  import uart_regs_pkg::*;
  logic [2:0] offset;
  logic [7:0] line_control;
  logic       feature_control_swap;
  logic       div_zero;
  reg_id_t    rd_sel;
  reg_id_t    wr_sel;

  modport dec  (input offset, line_control, feature_control_swap, div_zero,
                output rd_sel, wr_sel);
  modport user (output offset, line_control, feature_control_swap, div_zero,
                input rd_sel, wr_sel);
  modport rmux (input rd_sel);
endinterface

// [rtl/addr_decode.sv]
// decodes offset and mode bits into the register read and written
`timescale 1ns/10ps
module addr_decode (
  reg_sel_if.dec sel
);
  import uart_regs_pkg::*;

  logic enh;
  logic div;

  always_comb begin
    enh = (sel.line_control == ENH_KEY);
    div = sel.line_control[LCR_DIV_BIT] && !enh;
    sel.rd_sel = REG_NONE;
    sel.wr_sel = REG_NONE;
    case (sel.offset)
      OFS_HOLD: begin
        if (enh) begin
          sel.rd_sel = REG_FC;
          sel.wr_sel = REG_TRG;
        // divisor low, revision while divisor is zero
        end else if (div) begin
          sel.rd_sel = sel.div_zero ? REG_REV : REG_DLL;
          sel.wr_sel = REG_DLL;
        end else begin
          sel.rd_sel = REG_HOLD;
          sel.wr_sel = REG_HOLD;
        end
      end
      OFS_IER: begin
        if (enh) begin
          sel.rd_sel = REG_FEATURE_CONTROL;
          sel.wr_sel = REG_FEATURE_CONTROL;
        end else if (div) begin
          sel.rd_sel = sel.div_zero ? REG_IDENT : REG_DLM;
          sel.wr_sel = REG_DLM;
        end else begin
          sel.rd_sel = REG_IER;
          sel.wr_sel = REG_IER;
        end
      end
      OFS_ISR: begin
        if (enh) begin
          sel.rd_sel = REG_EFR;
          sel.wr_sel = REG_EFR;
        end else if (div) begin
          sel.rd_sel = REG_AFR;
          sel.wr_sel = REG_AFR;
        end else begin
          sel.rd_sel = REG_ISR;
          sel.wr_sel = REG_FCR;
        end
      end
      OFS_LCR: begin
        sel.rd_sel = REG_LCR;
        sel.wr_sel = REG_LCR;
      end
      OFS_MCR: begin
        sel.rd_sel = enh ? REG_XON1 : REG_MCR;
        sel.wr_sel = enh ? REG_XON1 : REG_MCR;
      end
      OFS_LSR: begin
        // status is read only; write falls on nothing, or on xon2 under the enhanced key
        sel.rd_sel = enh ? REG_XON2 : REG_LSR;
        sel.wr_sel = enh ? REG_XON2 : REG_NONE;
      end
      OFS_MSR: begin
        sel.rd_sel = enh ? REG_XOFF1 : REG_MSR;
        sel.wr_sel = enh ? REG_XOFF1 : REG_NONE;
      end
      OFS_SPR: begin
        if (enh) begin
          sel.rd_sel = REG_XOFF2;
          sel.wr_sel = REG_XOFF2;
        end else if (sel.feature_control_swap) begin
          sel.rd_sel = REG_FIFO_LEVEL_STATUS;
          sel.wr_sel = REG_ENHANCED_MODE_SELECT;
        end else begin
          sel.rd_sel = REG_SPR;
          sel.wr_sel = REG_SPR;
        end
      end
      default: begin
        sel.rd_sel = REG_NONE;
        sel.wr_sel = REG_NONE;
      end
    endcase
  end

endmodule

// [rtl/read_mux.sv]
// selects one channel's read data from stored and core-side values
`timescale 1ns/10ps
module read_mux #(
  parameter logic [7:0] REV_CODE   = 8'h5C,
  parameter logic [7:0] IDENT_CODE = 8'h3E
) (
  reg_sel_if.rmux                   sel,
  input  wire uart_regs_pkg::chan_regs_t regs,
  input  wire logic [7:0]           rx_data,
  input  wire logic [7:0]           int_status,
  input  wire logic [7:0]           line_status,
  input  wire logic [7:0]           modem_status,
  input  wire logic [7:0]           rx_level,
  input  wire logic [7:0]           tx_level,
  output logic [7:0]                data
);
  import uart_regs_pkg::*;

  always_comb begin
    case (sel.rd_sel)
      REG_HOLD:  data = rx_data;
      REG_DLL:   data = regs.dll;
      REG_DLM:   data = regs.divisor_high;
      REG_AFR:   data = regs.alternate_function;
      REG_REV:   data = REV_CODE;
      REG_IDENT: data = IDENT_CODE;
      REG_IER:   data = regs.interrupt_enable;
      REG_ISR:   data = int_status;
      REG_LCR:   data = regs.line_control;
      REG_MCR:   data = regs.modem_control;
      REG_LSR:   data = line_status;
      REG_MSR:   data = modem_status;
      REG_SPR:   data = regs.scratch_pad;
      // level counter picked by mode select
      REG_FIFO_LEVEL_STATUS:  data = regs.enhanced_mode_select[ENHANCED_MODE_SELECT_TXSEL_BIT] ? tx_level : rx_level;
      REG_FC:    data = regs.feature_control[FEATURE_CONTROL_TXSEL_BIT] ? tx_level : rx_level;
      REG_FEATURE_CONTROL:  data = regs.feature_control;
      REG_EFR:   data = regs.enhanced_function;
      REG_XON1:  data = regs.xon1;
      REG_XON2:  data = regs.xon2;
      REG_XOFF1: data = regs.xoff1;
      REG_XOFF2: data = regs.xoff2;
      default:   data = RST_ZERO;
    endcase
  end

endmodule

// [rtl/uart_channel_register_decode.sv]
// host register port and register banks of a multi-channel uart
`timescale 1ns/10ps
module uart_channel_register_decode
  import uart_regs_pkg::*;
#(
  parameter int         NCH        = 2,
  parameter logic [7:0] REV_CODE   = 8'h5C,
  parameter logic [7:0] IDENT_CODE = 8'h3E
) (
  input  wire logic                          clk,
  input  wire logic                          reset,
  input  wire logic                          cs_n,
  input  wire logic [$clog2(NCH)-1:0]        channel_select,
  input  wire logic [uart_regs_pkg::ADDR_W-1:0] addr,
  input  wire logic                          rd,
  input  wire logic                          wr,
  input  wire logic [uart_regs_pkg::DATA_W-1:0] data_in,
  output logic      [uart_regs_pkg::DATA_W-1:0] data_out,
  output logic                               data_oe,
  input  wire logic [NCH-1:0][7:0]           rx_data,
  input  wire logic [NCH-1:0][7:0]           int_status,
  input  wire logic [NCH-1:0][7:0]           line_status,
  input  wire logic [NCH-1:0][7:0]           modem_status,
  input  wire logic [NCH-1:0][7:0]           rx_level,
  input  wire logic [NCH-1:0][7:0]           tx_level,
  output uart_regs_pkg::chan_regs_t [NCH-1:0] cfg,
  output logic [NCH-1:0]                     tx_load,
  output logic [uart_regs_pkg::DATA_W-1:0]   tx_data,
  output logic [NCH-1:0]                     fcr_load,
  output logic [NCH-1:0]                     rx_pop
);
  import uart_regs_pkg::*;

  localparam int CH_W = $clog2(NCH);

  typedef struct packed {
    chan_regs_t [NCH-1:0] ch;
    logic [7:0]           dout;
    logic                 doe;
    logic                 rd_prev;
    logic [NCH-1:0]       tx_load;
    logic [7:0]           tx_data;
    logic [NCH-1:0]       fcr_load;
    logic [NCH-1:0]       rx_pop;
  } state_t;

  localparam state_t ST_RESET = '{
    ch:       {NCH{CH_RESET}},
    dout:     RST_ZERO,
    doe:      1'b0,
    rd_prev:  1'b0,
    tx_load:  '0,
    tx_data:  RST_ZERO,
    fcr_load: '0,
    rx_pop:   '0};

  state_t               st_reg;
  state_t               st_next;
  reg_id_t              rd_sel [NCH];
  reg_id_t              wr_sel [NCH];
  logic [NCH-1:0][7:0]  rdata;
  logic [NCH-1:0]       wr_hit;
  logic                 rd_take;
  logic                 wr_take;
  logic                 conc;

  // one decoder and read path per channel
  for (genvar i = 0; i < NCH; i++) begin : g_ch
    reg_sel_if u_sif ();

    assign u_sif.offset    = addr;
    assign u_sif.line_control       = st_reg.ch[i].line_control;
    assign u_sif.feature_control_swap = st_reg.ch[i].feature_control[FEATURE_CONTROL_SWAP_BIT];
    assign u_sif.div_zero  = (st_reg.ch[i].dll == RST_ZERO) &&
                             (st_reg.ch[i].divisor_high == RST_ZERO);
    assign rd_sel[i]       = u_sif.rd_sel;
    assign wr_sel[i]       = u_sif.wr_sel;

    addr_decode u_dec (
      .sel (u_sif)
    );

    read_mux #(
      .REV_CODE   (REV_CODE),
      .IDENT_CODE (IDENT_CODE)
    ) u_mux (
      .sel          (u_sif),
      .regs         (st_reg.ch[i]),
      .rx_data      (rx_data[i]),
      .int_status   (int_status[i]),
      .line_status  (line_status[i]),
      .modem_status (modem_status[i]),
      .rx_level     (rx_level[i]),
      .tx_level     (tx_level[i]),
      .data         (rdata[i])
    );

    assign wr_hit[i] = wr_take &&
                       ((channel_select == CH_W'(i)) || conc);
  end

  assign rd_take = !cs_n && rd;
  assign wr_take = !cs_n && wr;
  assign conc    = st_reg.ch[channel_select].alternate_function[AFR_CONC_BIT];

  always_comb begin
    st_next          = st_reg;
    st_next.tx_load  = '0;
    st_next.fcr_load = '0;
    st_next.rx_pop   = '0;
    st_next.doe      = rd_take;
    st_next.rd_prev  = rd_take;
    if (rd_take) begin
      st_next.dout = rdata[channel_select];
    end
    // side effect once per read, however long the strobe stands
    // receive holding pop
    if (rd_take && !st_reg.rd_prev &&
        rd_sel[channel_select] == REG_HOLD) begin
      st_next.rx_pop[channel_select] = 1'b1;
    end
    // writes only land on writable ids
    for (int i = 0; i < NCH; i++) begin
      if (wr_hit[i]) begin
        case (wr_sel[i])
          REG_HOLD: begin
            st_next.tx_load[i] = 1'b1;
            st_next.tx_data    = data_in;
          end
          REG_DLL:   st_next.ch[i].dll   = data_in;
          REG_DLM:   st_next.ch[i].divisor_high   = data_in;
          REG_AFR:   st_next.ch[i].alternate_function   = data_in;
          REG_IER:   st_next.ch[i].interrupt_enable   = data_in;
          REG_FCR: begin
            st_next.ch[i].fifo_control   = data_in;
            st_next.fcr_load[i] = 1'b1;
          end
          REG_LCR:   st_next.ch[i].line_control   = data_in;
          REG_MCR:   st_next.ch[i].modem_control   = data_in;
          REG_SPR:   st_next.ch[i].scratch_pad   = data_in;
          REG_ENHANCED_MODE_SELECT:  st_next.ch[i].enhanced_mode_select  = data_in;
          REG_TRG:   st_next.ch[i].fifo_trigger_level   = data_in;
          REG_FEATURE_CONTROL:  st_next.ch[i].feature_control  = data_in;
          REG_EFR:   st_next.ch[i].enhanced_function   = data_in;
          REG_XON1:  st_next.ch[i].xon1  = data_in;
          REG_XON2:  st_next.ch[i].xon2  = data_in;
          REG_XOFF1: st_next.ch[i].xoff1 = data_in;
          REG_XOFF2: st_next.ch[i].xoff2 = data_in;
          default:   st_next.ch[i]       = st_reg.ch[i];
        endcase
      end
    end
  end

  always_ff @(posedge clk or posedge reset) begin
    if (reset) begin
      st_reg <= ST_RESET;
    end else begin
      st_reg <= st_next;
    end
  end

  assign data_out = st_reg.dout;
  assign data_oe  = st_reg.doe;
  assign cfg      = st_reg.ch;
  assign tx_load  = st_reg.tx_load;
  assign tx_data  = st_reg.tx_data;
  assign fcr_load = st_reg.fcr_load;
  assign rx_pop   = st_reg.rx_pop;

  // checks on channel 0 are representative of every channel
  default clocking cb @(posedge clk);
  endclocking
  default disable iff (reset);

  logic       ch0_rd;
  logic       ch0_wr;
  logic       bf0;
  assign ch0_rd = rd_take && (channel_select == '0);
  assign ch0_wr = wr_hit[0];
  assign bf0    = (st_reg.ch[0].line_control == ENH_KEY);

  AST_CHANNEL_PRIVATE:
  assert property (wr_take && channel_select != '0 && !conc
                   |=> st_reg.ch[0] == $past(st_reg.ch[0]))
    else $error("write to another channel changed channel 0");

  AST_HOLD_WRITE:
  assert property (ch0_wr && addr == OFS_HOLD &&
                   !st_reg.ch[0].line_control[LCR_DIV_BIT]
                   |=> tx_load[0] && tx_data == $past(data_in))
    else $error("transmit holding load missing");

  AST_HOLD_READ:
  assert property (ch0_rd && !st_reg.rd_prev && addr == OFS_HOLD &&
                   !st_reg.ch[0].line_control[LCR_DIV_BIT]
                   |=> rx_pop[0] && data_oe &&
                       data_out == $past(rx_data[0]))
    else $error("receive holding read wrong");

  AST_DIVISOR_HIGH:
  assert property (ch0_wr && addr == OFS_IER && !bf0 &&
                   st_reg.ch[0].line_control[LCR_DIV_BIT]
                   |=> st_reg.ch[0].divisor_high == $past(data_in) &&
                       st_reg.ch[0].interrupt_enable == $past(st_reg.ch[0].interrupt_enable))
    else $error("divisor high write wrong");

  AST_SCRATCH:
  assert property (ch0_wr && addr == OFS_SPR && !bf0 &&
                   !st_reg.ch[0].feature_control[FEATURE_CONTROL_SWAP_BIT]
                   |=> st_reg.ch[0].scratch_pad == $past(data_in) &&
                       $stable(st_reg.ch[0].enhanced_mode_select))
    else $error("scratch pad write wrong");

  AST_LEVEL_READ:
  assert property (ch0_rd && addr == OFS_SPR && !bf0 &&
                   st_reg.ch[0].feature_control[FEATURE_CONTROL_SWAP_BIT]
                   |=> data_out == ($past(st_reg.ch[0].enhanced_mode_select[ENHANCED_MODE_SELECT_TXSEL_BIT])
                        ? $past(tx_level[0]) : $past(rx_level[0])))
    else $error("fifo level status read wrong");

  AST_MODE_SELECT:
  assert property (ch0_wr && addr == OFS_SPR && !bf0 &&
                   st_reg.ch[0].feature_control[FEATURE_CONTROL_SWAP_BIT]
                   |=> st_reg.ch[0].enhanced_mode_select == $past(data_in) &&
                       $stable(st_reg.ch[0].scratch_pad))
    else $error("mode select write wrong");

  AST_ENH_FLOW:
  assert property (ch0_wr && bf0 && addr == OFS_MCR
                   |=> st_reg.ch[0].xon1 == $past(data_in) &&
                       $stable(st_reg.ch[0].modem_control))
    else $error("flow-on character write wrong");

  AST_ENH_COUNT:
  assert property (ch0_rd && bf0 && addr == OFS_HOLD
                   |=> !rx_pop[0] &&
                       data_out == ($past(st_reg.ch[0].feature_control[FEATURE_CONTROL_TXSEL_BIT])
                        ? $past(tx_level[0]) : $past(rx_level[0])))
    else $error("fifo count read wrong");

  AST_RO_WRITE:
  assert property (wr_take && !conc && channel_select == '0 && !bf0 &&
                   (addr == OFS_LSR || addr == OFS_MSR)
                   |=> $stable(st_reg.ch) && tx_load == '0)
    else $error("write to status changed state");

endmodule

// [tb/host_model.sv]
// host bus model driving one register port cycle at a time
`timescale 1ns/10ps
module host_model (
  input  wire logic       clk,
  output logic            cs_n,
  output logic            channel_select,
  output logic [2:0]      addr,
  output logic            rd,
  output logic            wr,
  output logic [7:0]      data_in,
  input  wire logic [7:0] data_out,
  input  wire logic       data_oe
);
  initial begin
    cs_n = 1'b1;
    channel_select = 1'b0;
    addr = 3'h0;
    rd = 1'b0;
    wr = 1'b0;
    data_in = 8'h00;
  end

  task automatic wr_reg(input logic c, input logic [2:0] a,
                        input logic [7:0] d);
    @(posedge clk);
    cs_n <= 1'b0;
    channel_select <= c;
    addr <= a;
    data_in <= d;
    wr <= 1'b1;
    @(posedge clk);
    // released address and data show junk, never the old value
    cs_n <= 1'b1;
    wr <= 1'b0;
    addr <= ~a;
    data_in <= ~d;
    #1;
  endtask

  task automatic rd_reg(input logic c, input logic [2:0] a,
                        output logic [7:0] q, output logic ok);
    @(posedge clk);
    cs_n <= 1'b0;
    channel_select <= c;
    addr <= a;
    rd <= 1'b1;
    @(posedge clk);
    cs_n <= 1'b1;
    rd <= 1'b0;
    addr <= ~a;
    #1;
    q = data_out;
    ok = data_oe;
  endtask
endmodule

// [tb/tb_uart_channel_register_decode.sv]
// self-checking bench for the uart channel register decode
`timescale 1ns/10ps
module tb_uart_channel_register_decode;
  import uart_regs_pkg::*;
  // both codes arbitrary
  localparam logic [7:0] REV = 8'hA5;
  localparam logic [7:0] IDN = 8'h3C;
  logic             clk;
  logic             reset;
  logic             cs_n;
  logic             chs;
  logic             rd;
  logic             wr;
  logic             data_oe;
  logic [2:0]       addr;
  logic [7:0]       data_in;
  logic [7:0]       data_out;
  logic [7:0]       tx_data;
  logic [7:0]       d;
  logic [1:0][7:0]  rx_data;
  logic [1:0][7:0]  int_status;
  logic [1:0][7:0]  line_status;
  logic [1:0][7:0]  modem_status;
  logic [1:0][7:0]  rx_level;
  logic [1:0][7:0]  tx_level;
  logic [1:0]       tx_load;
  logic [1:0]       fcr_load;
  logic [1:0]       rx_pop;
  chan_regs_t [1:0] cfg;
  chan_regs_t       snap;
  logic [31:0]      seed = 32'h0000005B;
  int               n_mismatch = 0;
  int               compares = 0;
  int               cycles = 0;

  uart_channel_register_decode #(.NCH(2), .REV_CODE(REV),
    .IDENT_CODE(IDN)) uut (
    .clk(clk), .reset(reset), .cs_n(cs_n), .channel_select(chs),
    .addr(addr), .rd(rd), .wr(wr), .data_in(data_in),
    .data_out(data_out), .data_oe(data_oe), .rx_data(rx_data),
    .int_status(int_status), .line_status(line_status),
    .modem_status(modem_status), .rx_level(rx_level),
    .tx_level(tx_level), .cfg(cfg), .tx_load(tx_load),
    .tx_data(tx_data), .fcr_load(fcr_load), .rx_pop(rx_pop));

  host_model host (
    .clk(clk), .cs_n(cs_n), .channel_select(chs), .addr(addr),
    .rd(rd), .wr(wr), .data_in(data_in), .data_out(data_out),
    .data_oe(data_oe));

  function automatic logic [7:0] rnd();
    seed ^= seed << 13;
    seed ^= seed >> 17;
    seed ^= seed << 5;
    return seed[7:0];
  endfunction

  task automatic chk_byte(input logic [7:0] got, input logic [7:0] exp);
    compares++;
    if (got !== exp) begin
      n_mismatch++;
      $display("[ERR] t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask

  task automatic chk_cfg(input chan_regs_t got, input chan_regs_t exp);
    compares++;
    if (got !== exp) begin
      n_mismatch++;
      $display("[ERR] t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask

  task automatic rdc(input logic c, input logic [2:0] a,
                     input logic [7:0] e);
    logic [7:0] q;
    logic       ok;
    host.rd_reg(c, a, q, ok);
    chk_byte(q, e);
    chk_byte({7'h00, ok}, 8'h01);
  endtask

  // fresh core-side values, landing before the next request
  task automatic stir();
    @(posedge clk);
    rx_data <= {rnd(), rnd()};
    int_status <= {rnd(), rnd()};
    line_status <= {rnd(), rnd()};
    modem_status <= {rnd(), rnd()};
    rx_level <= {rnd(), rnd()};
    tx_level <= {rnd(), rnd()};
    #1;
  endtask

  task automatic results();
    $display("mismatches=%0d compares=%0d", n_mismatch, compares);
    if (n_mismatch == 0 && compares > 0) begin
      $display("bench passed");
    end else begin
      $display("bench failed");
    end
    $finish;
  endtask

  initial begin
    clk = 1'b0;
    forever #10 clk = ~clk;
  end

  // whole run needs well under a thousand cycles
  always @(posedge clk) begin
    cycles++;
    if (cycles == 3000) begin
      n_mismatch++;
      results();
    end
  end

  initial begin
    reset = 1'b1;
    {rx_data, int_status, line_status} = '0;
    {modem_status, rx_level, tx_level} = '0;
    repeat (12) @(posedge clk);
    reset <= 1'b0;
    stir();
    rdc(1'b0, OFS_LCR, 8'h00);
    rdc(1'b0, OFS_SPR, 8'hFF);
    chk_byte(cfg[0].enhanced_mode_select, 8'h80);
    rdc(1'b0, OFS_ISR, int_status[0]);
    rdc(1'b1, OFS_LSR, line_status[1]);
    rdc(1'b1, OFS_MSR, modem_status[1]);
    rdc(1'b0, OFS_HOLD, rx_data[0]);
    chk_byte({6'h00, rx_pop}, 8'h01);
    d = rnd();
    host.wr_reg(1'b0, OFS_HOLD, d);
    chk_byte(tx_data, d);
    chk_byte({6'h00, tx_load}, 8'h01);
    // divisor bank, any line_control with bit 7 set but the key
    d = rnd();
    d[7] = 1'b1;
    if (d == ENH_KEY) d = 8'h80;
    host.wr_reg(1'b0, OFS_LCR, d);
    rdc(1'b0, 3'h0, REV);
    rdc(1'b0, 3'h1, IDN);
    d = rnd() | 8'h01;
    host.wr_reg(1'b0, 3'h0, d);
    rdc(1'b0, 3'h0, d);
    d = rnd();
    host.wr_reg(1'b0, 3'h1, d);
    rdc(1'b0, 3'h1, d);
    d = rnd() & 8'hFE;
    host.wr_reg(1'b0, 3'h2, d);
    rdc(1'b0, 3'h2, d);
    chk_byte(cfg[1].dll, 8'h00);
    host.wr_reg(1'b0, OFS_LCR, 8'h00);
    d = rnd();
    host.wr_reg(1'b0, OFS_SPR, d);
    rdc(1'b0, OFS_SPR, d);
    rdc(1'b1, OFS_SPR, 8'hFF);
    // wrong-direction writes leave stored state alone
    snap = cfg[0];
    host.wr_reg(1'b0, OFS_LSR, rnd());
    host.wr_reg(1'b0, OFS_MSR, rnd());
    chk_cfg(cfg[0], snap);
    // enhanced bank
    host.wr_reg(1'b0, OFS_LCR, ENH_KEY);
    host.wr_reg(1'b0, 3'h1, 8'h40);
    rdc(1'b0, 3'h1, 8'h40);
    for (int a = 2; a < 8; a++) begin
      if (a == 3) continue;
      d = rnd();
      host.wr_reg(1'b0, 3'(a), d);
      rdc(1'b0, 3'(a), d);
    end
    stir();
    d = rnd();
    host.wr_reg(1'b0, 3'h0, d);
    chk_byte(cfg[0].fifo_trigger_level, d);
    rdc(1'b0, 3'h0, rx_level[0]);
    snap = cfg[0];
    host.wr_reg(1'b0, OFS_LCR, 8'h00);
    rdc(1'b0, OFS_SPR, rx_level[0]);
    d = rnd() | 8'h01;
    host.wr_reg(1'b0, OFS_SPR, d);
    chk_byte(cfg[0].enhanced_mode_select, d);
    chk_byte(cfg[0].scratch_pad, snap.scratch_pad);
    rdc(1'b0, OFS_SPR, tx_level[0]);
    d = rnd();
    host.wr_reg(1'b0, OFS_ISR, d);
    chk_byte({6'h00, fcr_load}, 8'h01);
    chk_byte(cfg[0].fifo_control, d);
    snap = cfg[0];
    // random traffic on the second channel
    for (int i = 0; i < 24; i++) begin
      d = rnd();
      host.wr_reg(1'b1, (d[0] ? OFS_MCR : OFS_SPR), d);
      rdc(1'b1, (d[0] ? OFS_MCR : OFS_SPR), d);
    end
    chk_cfg(cfg[0], snap);
    results();
  end
endmodule
